// ---- rtl/fru_round_unit.sv ----
// Behaviour
// - accumulator holds lead, fraction, guard, round, sticky
// - single precision uses a 23-bit fraction
// - carry bit catches carry out of significand
// - lead bit loaded with operand implicit bit
// - sticky is OR of all lower bits
// - left shifts move guard, round; zero enters round
// - classify guard/round/sticky into four cases
// - normalize first, then round by selected mode
// - rounding carry shifts right, bumps exponent
// - store retained bits, clear lower result bits
// - guard/round/sticky positions depend on precision
// - nonzero guard/round/sticky flags inexact
// - nearest with guard zero truncates
// - nearest, guard and round-or-sticky increments
// - nearest midpoint ties to even
// - nearest at maximum magnitude: guard gives infinity
// - toward zero picks smaller magnitude candidate
// - plus infinity upper, minus infinity lower candidate
// - short precision normalized or denormalized first
`timescale 1ns/1ps
`include "fru_map.svh"
module fru_round_unit (
   // clock, reset, enable
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   // register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // status and result
   output logic             o_busy,
   output logic             o_inexact,
   output logic      [63:0] o_result
);
   import fru_pkg::*;

   fru_state_type q;
   fru_state_type n;

   logic [2:0]  grs_w;
   logic        inx_w;
   logic        lsb_w;
   logic        inc_w;
   logic        ismax_w;
   logic [55:0] keep_w;
   logic [55:0] ulp_w;
   logic [55:0] trunc_w;
   logic [11:0] emax_w;
   logic [11:0] einf_w;
   logic [56:0] next_higher_value;
   logic [56:0] next_lower_value;
   logic [56:0] upper_bound_candidate;
   logic [56:0] lower_bound_candidate;
   logic [56:0] pick_w;
   logic [55:0] rsig_w;
   logic [11:0] rexp_w;
   logic        rcy_w;
   logic        rinf_w;
   logic        cmd_w;
   fru_op_type  op_w;
   fru_cls_type cls_w;

   function automatic logic [55:0] keep_of(input logic sp);
      keep_of = sp ? `FRU_KEEP_S : `FRU_KEEP_D;
   endfunction

   function automatic logic [55:0] ulp_of(input logic sp);
      ulp_of = sp ? `FRU_ULP_S : `FRU_ULP_D;
   endfunction

   // effective guard, round, sticky for the target precision
   function automatic logic [2:0] grs_of(input logic [55:0] a,
                                         input logic sp);
      grs_of = sp ? {a[31], a[30], |a[29:0]} : a[2:0];
   endfunction

   assign cmd_w = i_wr && (i_addr == `FRU_A_CMD);
   assign op_w  = fru_op_type'(i_wdata[2:0]);

   // rounding datapath, only consumed in the round state
   always_comb begin
      keep_w  = keep_of(q.prec);
      ulp_w   = ulp_of(q.prec);
      grs_w   = grs_of(q.acc, q.prec);
      inx_w   = |grs_w;
      lsb_w   = |(q.acc & ulp_w);
      trunc_w = q.acc & keep_w;
      emax_w  = q.prec ? `FRU_EMAX_S : `FRU_EMAX_D;
      einf_w  = q.prec ? `FRU_EINF_S : `FRU_EINF_D;
      ismax_w = (&(q.acc | ~keep_w)) && (q.expo == emax_w);
      if (grs_w[2])
         cls_w = (grs_w[1] | grs_w[0]) ? GRS_HIGH : GRS_MID;
      else
         cls_w = (grs_w[1] | grs_w[0]) ? GRS_LOW : GRS_EXACT;
      // magnitudes; sign decides which is above in value
      next_lower_value  = {1'b0, trunc_w};
      next_higher_value = {1'b0, trunc_w} + (inx_w ? {1'b0, ulp_w} : 57'h0);
      upper_bound_candidate = q.sgn ? next_lower_value
                                    : next_higher_value;
      lower_bound_candidate = q.sgn ? next_higher_value
                                    : next_lower_value;
      // nearest: guard clear truncates, round/sticky or odd lsb bumps
      inc_w = grs_w[2] & (grs_w[1] | grs_w[0] | lsb_w);
      unique case (q.mode)
         RM_NEAR: pick_w = inc_w ? next_higher_value : next_lower_value;
         RM_ZERO: pick_w = next_lower_value;
         RM_PINF: pick_w = upper_bound_candidate;
         RM_MINF: pick_w = lower_bound_candidate;
      endcase
      rcy_w  = pick_w[56];
      rsig_w = pick_w[55:0];
      rexp_w = q.expo;
      if (rcy_w) begin
         rsig_w = pick_w[56:1];
         rexp_w = q.expo + 12'h001;
      end
      rinf_w = (q.mode == RM_NEAR) && ismax_w && grs_w[2];
      if (rinf_w)
         rexp_w = einf_w;
      if (rexp_w == einf_w)
         rsig_w = {1'b1, 55'h0};
      rsig_w = rsig_w & keep_w;
   end

   always_comb begin
      n       = q;
      n.rdata = 32'h0;
      if (i_rd) begin
         unique case (i_addr)
            `FRU_A_CTRL: n.rdata = {29'h0, q.prec, q.mode};
            `FRU_A_DINH: n.rdata = {8'h0, q.din_hi};
            `FRU_A_DINL: n.rdata = q.din_lo;
            `FRU_A_EXP:  n.rdata = {18'h0, q.cy, q.sgn, q.expo};
            `FRU_A_ACCH: n.rdata = {8'h0, q.acc[55:32]};
            `FRU_A_ACCL: n.rdata = q.acc[31:0];
            `FRU_A_STAT: n.rdata = {27'h0, q.cls, q.ovf, q.inexact,
                                    q.st != ST_IDLE};
            `FRU_A_RESH: n.rdata = q.res[63:32];
            `FRU_A_RESL: n.rdata = q.res[31:0];
            default:     n.rdata = 32'h0;
         endcase
      end
      if (i_wr) begin
         unique case (i_addr)
            `FRU_A_CTRL: begin
               n.mode = fru_mode_type'(i_wdata[1:0]);
               n.prec = i_wdata[`FRU_CTRL_PREC];
            end
            `FRU_A_DINH: n.din_hi = i_wdata[23:0];
            `FRU_A_DINL: n.din_lo = i_wdata;
            `FRU_A_EXP: begin
               n.din_exp = i_wdata[11:0];
               n.din_sgn = i_wdata[`FRU_EXP_SGN];
            end
            `FRU_A_STAT: begin
               // a round finishing this cycle overrides below
               n.inexact = 1'b0;
               n.ovf     = 1'b0;
            end
            default: ;
         endcase
      end
      unique case (q.st)
         ST_IDLE: begin
            // commands while busy are dropped
            if (cmd_w) begin
               unique case (op_w)
                  OP_LOAD: begin
                     n.sgn = q.din_sgn;
                     n.expo = q.din_exp;
                     n.cy = 1'b0;
                     n.acc = {|q.din_exp, q.din_hi[22:0], q.din_lo};
                  end
                  OP_ADD: begin
                     {n.cy, n.acc} = {1'b0, q.acc}
                                   + {1'b0, q.din_hi, q.din_lo};
                  end
                  OP_SHR: begin
                     n.cy   = 1'b0;
                     n.acc  = {q.cy, q.acc[55:2], q.acc[1] | q.acc[0]};
                     n.expo = q.expo + 12'h001;
                  end
                  OP_ROUND: begin
                     n.st      = ST_NORM;
                     n.inexact = 1'b0;
                     n.ovf     = 1'b0;
                  end
                  default: ;
               endcase
            end
         end
         ST_NORM: begin
            if (q.cy) begin
               n.cy   = 1'b0;
               n.acc  = {1'b1, q.acc[55:2], q.acc[1] | q.acc[0]};
               n.expo = q.expo + 12'h001;
            end else if (!q.acc[55] && (|q.acc[55:1])
                         && (q.expo > `FRU_EMIN)) begin
               // stops at the minimum exponent: denormal form
               n.acc  = {q.acc[54:1], 1'b0, q.acc[0]};
               n.expo = q.expo - 12'h001;
            end else begin
               n.st = ST_ROUND;
            end
         end
         ST_ROUND: begin
            n.st      = ST_IDLE;
            n.cls     = cls_w;
            n.inexact = inx_w;
            n.ovf     = (rexp_w == einf_w);
            n.cy      = 1'b0;
            n.acc     = rsig_w;
            n.expo    = rexp_w;
            n.res     = {q.sgn, rsig_w[55] ? rexp_w[10:0] : 11'h0,
                         rsig_w[54:3]};
         end
         default: n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn)
         q <= `FRU_STATE_RST;
      else if (i_ce)
         q <= n;
   end

   assign o_rdata   = q.rdata;
   assign o_busy    = (q.st != ST_IDLE);
   assign o_inexact = q.inexact;
   assign o_result  = q.res;

   // checks
   logic rnd_go;
   assign rnd_go = i_ce && (q.st == ST_ROUND);
   localparam int rnd_max = `FRU_RND_MAX;

   property p_shr_sticky;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_ce && q.st == ST_IDLE && cmd_w && op_w == OP_SHR)
         |=> q.acc[0] == ($past(q.acc[1]) | $past(q.acc[0]));
   endproperty
   a_shr_sticky: assert property (p_shr_sticky)
      else $error("sticky lost on right shift");

   property p_left_zero;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_ce && q.st == ST_NORM && !q.cy && !q.acc[55] && (|q.acc[55:1])
       && q.expo > `FRU_EMIN)
         |=> !q.acc[1] && q.acc[55:2] == $past(q.acc[54:1]);
   endproperty
   a_left_zero: assert property (p_left_zero)
      else $error("left shift did not insert zero at round bit");

   property p_load_lead;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_ce && q.st == ST_IDLE && cmd_w && op_w == OP_LOAD)
         |=> q.acc[55] == (|$past(q.din_exp)) && !q.cy;
   endproperty
   a_load_lead: assert property (p_load_lead)
      else $error("lead bit not loaded from exponent");

   property p_inexact;
      @(posedge i_mclk) disable iff (!i_rstn)
      rnd_go |=> q.inexact == (|$past(grs_w));
   endproperty
   a_inexact: assert property (p_inexact)
      else $error("inexact does not match guard round sticky");

   property p_zero_trunc;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.mode == RM_ZERO && q.expo < emax_w)
         |=> q.res[51:0] == $past(trunc_w[54:3]);
   endproperty
   a_zero_trunc: assert property (p_zero_trunc)
      else $error("toward zero did not truncate");

   property p_carry_exp;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && rcy_w && !rinf_w)
         |=> q.expo == $past(q.expo) + 12'h001 && q.acc[55];
   endproperty
   a_carry_exp: assert property (p_carry_exp)
      else $error("rounding carry did not bump exponent");

   property p_max_inf;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.mode == RM_NEAR && ismax_w && grs_w[2])
         |=> q.ovf && q.res[51:0] == 52'h0 && q.expo == $past(einf_w);
   endproperty
   a_max_inf: assert property (p_max_inf)
      else $error("maximum magnitude did not round to infinity");

   property p_single_low;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.prec) |=> q.res[28:0] == 29'h0;
   endproperty
   a_single_low: assert property (p_single_low)
      else $error("low result bits not cleared in single");

   property p_round_done;
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_ce && q.st == ST_IDLE && cmd_w && op_w == OP_ROUND)
         |=> o_busy ##[0:rnd_max] (q.st == ST_IDLE);
   endproperty
   a_round_done: assert property (p_round_done)
      else $error("round did not finish in time");

   property p_class;
      @(posedge i_mclk) disable iff (!i_rstn)
      rnd_go |=> q.cls == {$past(grs_w[2]), $past(grs_w[1]) | $past(grs_w[0])};
   endproperty
   a_class: assert property (p_class)
      else $error("guard round sticky class wrong");

   property p_near_trunc;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.mode == RM_NEAR && !grs_w[2] && q.expo <= emax_w)
         |=> q.acc == $past(trunc_w);
   endproperty
   a_near_trunc: assert property (p_near_trunc)
      else $error("nearest with guard clear did not truncate");

   property p_near_up;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.mode == RM_NEAR && grs_w[2] && (grs_w[1] | grs_w[0])
       && !rcy_w && q.expo <= emax_w)
         |=> q.acc == $past(trunc_w) + $past(ulp_w);
   endproperty
   a_near_up: assert property (p_near_up)
      else $error("nearest above midpoint did not increment");

   property p_minus_low;
      @(posedge i_mclk) disable iff (!i_rstn)
      (rnd_go && q.mode == RM_MINF && !q.sgn && q.expo <= emax_w)
         |=> q.acc == $past(trunc_w);
   endproperty
   a_minus_low: assert property (p_minus_low)
      else $error("toward minus infinity did not pick the lower value");

   property p_norm_first;
      @(posedge i_mclk) disable iff (!i_rstn)
      rnd_go |-> !q.cy && (q.acc[55] || q.expo <= `FRU_EMIN || q.acc[55:1] == 55'h0);
   endproperty
   a_norm_first: assert property (p_norm_first)
      else $error("rounding started on an unnormalized value");

   c_tie_even: cover property (@(posedge i_mclk) disable iff (!i_rstn)
      rnd_go && q.mode == RM_NEAR && cls_w == GRS_MID);
   c_carry: cover property (@(posedge i_mclk) disable iff (!i_rstn)
      rnd_go && rcy_w);
   c_inf: cover property (@(posedge i_mclk) disable iff (!i_rstn)
      rnd_go && rinf_w);
   c_single: cover property (@(posedge i_mclk) disable iff (!i_rstn)
      rnd_go && q.prec && inx_w);
endmodule // fru_round_unit

// ---- rtl/fru_map.svh ----
`ifndef FRU_MAP_SVH
`define FRU_MAP_SVH
// register word addresses
`define FRU_A_CTRL   4'h0
`define FRU_A_CMD    4'h1
`define FRU_A_DINH   4'h2
`define FRU_A_DINL   4'h3
`define FRU_A_EXP    4'h4
`define FRU_A_ACCH   4'h5
`define FRU_A_ACCL   4'h6
`define FRU_A_STAT   4'h7
`define FRU_A_RESH   4'h8
`define FRU_A_RESL   4'h9
// field positions
`define FRU_CTRL_PREC 2
`define FRU_EXP_SGN   12
// reset value of the whole state
`define FRU_STATE_RST '0
// exponent limits, biased in the target format
`define FRU_EMIN   12'h001
`define FRU_EMAX_D 12'h7FE
`define FRU_EINF_D 12'h7FF
`define FRU_EMAX_S 12'h0FE
`define FRU_EINF_S 12'h0FF
// retained-bit masks and unit in last place
`define FRU_KEEP_D 56'hFFFFFFFFFFFFF8
`define FRU_KEEP_S 56'hFFFFFF00000000
`define FRU_ULP_D  56'h00000000000008
`define FRU_ULP_S  56'h00000100000000
// worst-case cycles from round command to idle
`define FRU_RND_MAX 60
`endif

// ---- rtl/fru_pkg.sv ----
package fru_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_ROUND} fru_st_type;
   typedef enum logic [1:0] {
      RM_NEAR = 2'h0, RM_ZERO = 2'h1, RM_PINF = 2'h2, RM_MINF = 2'h3
   } fru_mode_type;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0, OP_LOAD = 3'h1, OP_ADD = 3'h2,
      OP_SHR = 3'h3, OP_ROUND = 3'h4
   } fru_op_type;
   typedef enum logic [1:0] {
      GRS_EXACT = 2'h0, GRS_LOW = 2'h1, GRS_MID = 2'h2, GRS_HIGH = 2'h3
   } fru_cls_type;
   typedef struct packed {
      fru_st_type   st;
      fru_mode_type mode;
      logic         prec;
      logic         sgn;
      logic         cy;
      logic [55:0]  acc;
      logic [11:0]  expo;
      logic [23:0]  din_hi;
      logic [31:0]  din_lo;
      logic [11:0]  din_exp;
      logic         din_sgn;
      logic         inexact;
      logic         ovf;
      fru_cls_type  cls;
      logic [63:0]  res;
      logic [31:0]  rdata;
   } fru_state_type;
endpackage

// ---- sim/fru_pipe_model.sv ----
`timescale 1ns/1ps
module fru_pipe_model (
   // clock
   input  wire logic        i_mclk,
   // register port toward the round unit
   output logic      [3:0]  o_addr,
   output logic      [31:0] o_wdata,
   output logic             o_wr,
   output logic             o_rd,
   // read data back
   input  wire logic [31:0] i_rdata
);
   initial begin
      o_addr  = 4'h0;
      o_wdata = 32'h0;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end
   // data is inverted after the strobe so a late sample cannot pass by luck
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_mclk);
      o_wr    <= 1'b0;
      o_wdata <= ~d;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_mclk);
      o_rd   <= 1'b0;
      @(negedge i_mclk);
      d = i_rdata;
   endtask
endmodule // fru_pipe_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`include "fru_map.svh"
module testbench;
   import fru_pkg::*;
   logic        mclk;
   logic        rstn;
   logic        ce;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        busy;
   logic        inexact;
   logic [63:0] result;
   int          miscompares;
   int          checked;

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   fru_round_unit uut (.i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_busy(busy),
      .o_inexact(inexact), .o_result(result));

   fru_pipe_model pipe (.i_mclk(mclk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd), .i_rdata(rdata));

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test;
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // reference rounding: {inexact, sign, exp, frac}; input already normalized
   function automatic logic [64:0] model_round(input logic [1:0] m, input logic p,
         input logic s, input logic [11:0] e, input logic [55:0] a);
      logic [52:0] k;
      logic        g;
      logic        r;
      logic        x;
      logic        lsb;
      logic        inc;
      k   = p ? {1'b0, a[54:32], 29'h0} : {1'b0, a[54:3]};
      g   = p ? a[31] : a[2];
      r   = p ? a[30] : a[1];
      x   = p ? |a[29:0] : a[0];
      lsb = p ? a[32] : a[3];
      case (m)
         2'h0: inc = g & (r | x | lsb);
         2'h1: inc = 1'b0;
         2'h2: inc = (g | r | x) & ~s;
         default: inc = (g | r | x) & s;
      endcase
      k = k + ({52'h0, inc} << (p ? 29 : 0));
      // all-ones plus one lands on the next binade, or infinity at the top
      if (k[52]) begin
         e = e + 12'h001;
         k = 53'h0;
      end
      return {g | r | x, s, e[10:0], k[51:0]};
   endfunction

   task automatic run(input logic [1:0] m, input logic p, input logic s,
         input logic [11:0] e, input logic [55:0] a, input logic [2:0] op,
         input logic [55:0] b, input logic [64:0] want);
      logic [31:0] hi;
      logic [31:0] lo;
      int          n;
      pipe.wr(`FRU_A_CTRL, {29'h0, p, m});
      pipe.wr(`FRU_A_DINH, {8'h0, a[55:32]});
      pipe.wr(`FRU_A_DINL, a[31:0]);
      pipe.wr(`FRU_A_EXP, {19'h0, s, e});
      pipe.wr(`FRU_A_CMD, {29'h0, OP_LOAD});
      if (op != OP_NONE) begin
         pipe.wr(`FRU_A_DINH, {8'h0, b[55:32]});
         pipe.wr(`FRU_A_DINL, b[31:0]);
         pipe.wr(`FRU_A_CMD, {29'h0, op});
      end
      pipe.wr(`FRU_A_CMD, {29'h0, OP_ROUND});
      @(negedge mclk);
      check({63'h0, busy}, 64'h1);
      n = 0;
      while (busy !== 1'b0) begin
         @(negedge mclk);
         n++;
         if (n > `FRU_RND_MAX) begin
            miscompares++;
            end_of_test();
         end
      end
      check(result, want[63:0]);
      check({63'h0, inexact}, {63'h0, want[64]});
      pipe.rd(`FRU_A_RESH, hi);
      pipe.rd(`FRU_A_RESL, lo);
      check({hi, lo}, want[63:0]);
   endtask

   initial begin : main
      logic [31:0] d;
      logic [55:0] a;
      logic [55:0] sp [3];
      miscompares = 0;
      checked     = 0;
      rstn        = 1'b0;
      ce          = 1'b1;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      @(negedge mclk);
      check(result, 64'h0);
      check({62'h0, busy, inexact}, 64'h0);
      pipe.rd(`FRU_A_CTRL, d);
      check({32'h0, d}, 64'h0);
      pipe.wr(4'hF, 32'hFFFFFFFF);
      pipe.rd(4'hC, d);
      check({32'h0, d}, 64'h0);
      // a write while the enable is low must leave the mode alone
      @(posedge mclk);
      ce <= 1'b0;
      pipe.wr(`FRU_A_CTRL, 32'h00000007);
      ce <= 1'b1;
      pipe.rd(`FRU_A_CTRL, d);
      check({32'h0, d}, 64'h0);
      // every mode, sign, guard/round/sticky pattern and retained lsb
      for (int i = 0; i < 128; i++) begin
         a = {1'b1, 51'h2AAAAAAAAAAAA, i[3], i[2:0]};
         run(i[6:5], 1'b0, i[4], 12'h400, a, OP_NONE, 56'h0,
             model_round(i[6:5], 1'b0, i[4], 12'h400, a));
      end
      // single: sticky from the dedicated bit, from the middle, and a tie
      sp[0] = {1'b1, 23'h555555, 2'h2, 30'h00000001};
      sp[1] = {1'b1, 23'h7FFFFF, 2'h0, 30'h00000020};
      sp[2] = {1'b1, 23'h2AAAAA, 2'h2, 30'h00000000};
      for (int j = 0; j < 3; j++) begin
         for (int i = 0; i < 8; i++) begin
            run(i[1:0], 1'b1, i[2], 12'h080, sp[j], OP_NONE, 56'h0,
                model_round(i[1:0], 1'b1, i[2], 12'h080, sp[j]));
         end
      end
      run(2'h0, 1'b0, 1'b0, 12'h400, {1'b1, 52'hFFFFFFFFFFFFF, 3'h4}, OP_NONE, 56'h0,
          {1'b1, 1'b0, 11'h401, 52'h0});
      run(2'h0, 1'b0, 1'b1, 12'h7FE, {1'b1, 52'hFFFFFFFFFFFFF, 3'h4}, OP_NONE, 56'h0,
          {1'b1, 1'b1, 11'h7FF, 52'h0});
      run(2'h0, 1'b0, 1'b0, 12'h7FE, {1'b1, 52'hFFFFFFFFFFFFF, 3'h3}, OP_NONE, 56'h0,
          {1'b1, 1'b0, 11'h7FE, 52'hFFFFFFFFFFFFF});
      run(2'h0, 1'b0, 1'b0, 12'h400, 56'h80000000000001, OP_ADD, 56'h80000000000002,
          {1'b1, 1'b0, 11'h401, 52'h0});
      pipe.rd(`FRU_A_EXP, d);
      check({32'h0, d}, 64'h401);
      pipe.rd(`FRU_A_ACCH, d);
      check({32'h0, d}, 64'h800000);
      run(2'h0, 1'b0, 1'b0, 12'h400, 56'h8000000000000C, OP_SHR, 56'h0,
          {1'b1, 1'b0, 11'h400, 52'h2});
      // midpoint class, inexact set, no overflow, idle
      pipe.rd(`FRU_A_STAT, d);
      check({32'h0, d}, 64'h12);
      pipe.wr(`FRU_A_STAT, 32'h0);
      @(negedge mclk);
      check({63'h0, inexact}, 64'h0);
      end_of_test();
   end
endmodule // testbench
